// File: csr_pkg.sv
/*
  Constants, types and shared functions of the cascade stage regulator.
  Assumes one 100 MHz control clock; temperatures in signed 0.1 K units.
*/
package csr_pkg;
  localparam int CLK_HZ       = 100_000_000;
  localparam int BAUD         = 9600;
  localparam int BIT_CYC_DEF  = CLK_HZ / BAUD;
  localparam int GAP_BITS     = 39; // 3.5 chars of 11 bits, rounded up
  localparam int TICK_MS      = 1000;
  localparam int TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int NCAT      = 2;
  localparam int NSTG      = 10;
  localparam int NBAND     = 4;
  localparam int NLOG      = 4;
  localparam int STG_MIN   = 1;
  localparam int STG_MAX   = 10;
  // Writable word map
  localparam int C_SETPT   = 0;
  localparam int C_BAND    = 1;
  localparam int C_RUN     = 2;
  localparam int C_MODE    = 3;
  localparam int C_SRC     = 4;
  localparam int C_CAT     = 5;
  localparam int C_STRIDE  = 7;
  localparam int K_STG     = 0;
  localparam int K_PRIO    = 1;
  localparam int K_PWR     = 2;
  localparam int K_INHT    = 3;
  localparam int K_ENI     = 4;
  localparam int K_INHI    = 5;
  localparam int K_MINON   = 6;
  localparam int C_TB      = 20;
  localparam int TB_STRIDE = 4;
  localparam int TB_START  = 0;
  localparam int TB_END    = 1;
  localparam int TB_SP     = 2;
  localparam int TB_EN     = 3;
  localparam int NCFG      = 36;
  localparam logic [15:0] SETPT_RST = 16'h01C2;
  localparam logic [15:0] BAND_RST  = 16'h0014; // 2.0 degC
  localparam logic [15:0] RUN_RST   = 16'h0001;
  localparam logic [15:0] STG_RST   = 16'h0001;
  localparam logic [15:0] INHT_RST  = 16'h003C;
  localparam logic [15:0] ENI_RST   = 16'h0258;
  localparam logic [15:0] INHI_RST  = 16'h0258;
  localparam logic [15:0] MINON_RST = 16'h0078;
  // Read-only status words
  localparam logic [15:0] ST_BASE = 16'h0100;
  localparam int ST_N    = 12;
  localparam int ST_SUP  = 0;
  localparam int ST_RET  = 1;
  localparam int ST_REG  = 2;
  localparam int ST_UNL  = 3;
  localparam int ST_STG0 = 4;
  localparam int ST_STG1 = 5;
  localparam int ST_ALM  = 6;
  localparam int ST_ACNT = 7;
  localparam int ST_LOG  = 8;
  // Serial slave
  localparam logic [7:0]  SLAVE_ADDR_DEF = 8'h01;
  localparam logic [7:0]  FN_RD    = 8'h03;
  localparam logic [7:0]  FN_WR    = 8'h06;
  localparam logic [7:0]  FN_EXC   = 8'h80;
  localparam logic [7:0]  EX_FN    = 8'h01;
  localparam logic [7:0]  EX_ADR   = 8'h02;
  localparam logic [7:0]  EX_VAL   = 8'h03;
  localparam int          MAX_QTY  = 8;
  localparam int          REQ_LEN  = 8;
  localparam int          ECHO_LEN = 6;
  localparam int          EXC_LEN  = 3;
  localparam int          RD_HDR   = 3;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  typedef enum logic [1:0] {
    MODE_OFF  = 2'b00,
    MODE_HEAT = 2'b01,
    MODE_COOL = 2'b10
  } csr_mode_t;

  typedef enum logic {
    MB_RX = 1'b0,
    MB_TX = 1'b1
  } csr_mb_t;

  typedef struct packed {
    logic [15:0] supply;
    logic [15:0] ret;
  } csr_temps_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// File: csr_regulator.sv
/*
  Cascade stage regulator: mode selector, alarm contact, staged
  on/off regulation with energy integrals, and a serial RTU slave.
  Assumes synchronous inputs and a half-duplex driver on the line.
*/
// Contract
// - Selector W heats, Y cools, 0 off
// - Alarm closes normally-open contact side
// - Alarm opens normally-closed contact side
// - Regulate within band, default 2 degC
// - Select supply or return as regulated
// - Four daily bands with own set-point
// - Category power and switch-on priority (power word K_PWR is stored but never used)
// - Stage count accepted only 1 to 10
// - Inhibition time after stage change
// - Stage stays on minimum on-time
// - First stage of top category never locked
// - Locked off, unlocked on except last
// - Last stage follows band edges
// - Shortage reaching enabling integral unlocks stage
// - Excess reaching inhibition integral locks stage
// - Slave only; master starts every transaction
// - Master reads data, states, alarms, log
// - Master writes on/off, mode, set-points, bands
module csr_regulator import csr_pkg::*; #(
  parameter int         BIT_CYC    = BIT_CYC_DEF,
  parameter int         TICK_CYC   = TICK_CYC_DEF,
  parameter logic [7:0] SLAVE_ADDR = SLAVE_ADDR_DEF
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  input  wire csr_temps_t           temps_in,
  input  wire logic [1:0]           selector_in,
  input  wire logic [10:0]          time_of_day_in,
  input  wire logic [NCAT*NSTG-1:0] unit_alarm_in,
  input  wire logic                 water_alarm_in,
  input  wire logic                 modbus_rx_in,
  output logic                      modbus_tx_out,
  output logic                      modbus_de_out,
  output logic [NCAT*NSTG-1:0]      stage_on_out,
  output logic                      heat_out,
  output logic                      cool_out,
  output logic                      alarm_no_out,
  output logic                      alarm_nc_out
);
  logic [15:0]        cfg_reg [NCFG];
  logic [15:0]        cat_p   [NCAT][C_STRIDE];
  logic [15:0]        alog_reg [NLOG];
  logic [15:0]        acnt_reg;
  logic               alarm_reg;
  csr_mode_t          mode;
  logic signed [15:0] act_sp;
  logic signed [15:0] reg_t;
  logic signed [16:0] dev;
  logic signed [16:0] half;
  logic [4:0]         stg [NCAT];
  logic               pc;
  logic               lcat;
  logic               ncat;
  logic [4:0]         n_first;
  logic [4:0]         total;
  logic [4:0]         unl_reg;
  logic               last_on_reg;
  logic [15:0]        since_reg;
  logic [15:0]        on_time_reg;
  logic [31:0]        short_reg;
  logic [31:0]        exc_reg;
  logic [26:0]        tick_cnt_reg;
  logic               tick;
  logic [NCAT*NSTG-1:0] stage_next;

  // Category parameters
  always_comb begin
    for (int c = 0; c < NCAT; c++) begin
      for (int k = 0; k < C_STRIDE; k++) begin
        cat_p[c][k] = cfg_reg[C_CAT + c * C_STRIDE + k];
      end
      stg[c] = cat_p[c][K_STG][4:0];
    end
  end

  // Band set-point; a later band wins an overlap
  always_comb begin
    act_sp = cfg_reg[C_SETPT];
    for (int b = 0; b < NBAND; b++) begin
      if (cfg_reg[C_TB + b * TB_STRIDE + TB_EN][0] &&
          {5'h00, time_of_day_in} >=
            cfg_reg[C_TB + b * TB_STRIDE + TB_START] &&
          {5'h00, time_of_day_in} <
            cfg_reg[C_TB + b * TB_STRIDE + TB_END]) begin
        act_sp = cfg_reg[C_TB + b * TB_STRIDE + TB_SP];
      end
    end
  end

  // Selector first; remote run and changeover act inside it
  always_comb begin
    if (selector_in == MODE_OFF || !cfg_reg[C_RUN][0]) begin
      mode = MODE_OFF;
    end else if (cfg_reg[C_MODE][1:0] == MODE_HEAT) begin
      mode = MODE_HEAT;
    end else if (cfg_reg[C_MODE][1:0] == MODE_COOL) begin
      mode = MODE_COOL;
    end else if (selector_in == MODE_COOL) begin
      mode = MODE_COOL;
    end else begin
      mode = MODE_HEAT;
    end
  end

  assign reg_t = cfg_reg[C_SRC][0] ? temps_in.ret
                                   : temps_in.supply;
  // Positive deviation is always a shortage
  assign dev  = (mode == MODE_COOL) ? (17'(reg_t) - 17'(act_sp))
                                    : (17'(act_sp) - 17'(reg_t));
  assign half = 17'(cfg_reg[C_BAND] >> 1);

  // Lower priority value runs first
  assign pc      = cat_p[1][K_PRIO] < cat_p[0][K_PRIO];
  assign n_first = stg[pc];
  assign total   = stg[0] + stg[1];
  assign lcat    = (unl_reg - 5'd1 < n_first) ? pc : ~pc;
  assign ncat    = (unl_reg < n_first) ? pc : ~pc;
  assign tick    = tick_cnt_reg == 27'(TICK_CYC - 1);

  genvar gc, gi;
  generate
    for (gc = 0; gc < NCAT; gc++) begin : g_cat
      for (gi = 0; gi < NSTG; gi++) begin : g_stg
        logic [4:0] pos;
        assign pos = (pc == gc) ? 5'(gi) : n_first + 5'(gi);
        assign stage_next[gc * NSTG + gi] = (5'(gi) < stg[gc]) &&
          ((pos + 5'd1 < unl_reg) ||
           (pos + 5'd1 == unl_reg && last_on_reg));
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 27'd1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_on_out <= '0;
      heat_out     <= 1'b0;
      cool_out     <= 1'b0;
    end else begin
      stage_on_out <= (mode == MODE_OFF) ? '0 : stage_next;
      heat_out     <= mode == MODE_HEAT;
      cool_out     <= mode == MODE_COOL;
    end
  end

  // Cascade: unlock beats lock beats band switching
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unl_reg     <= 5'd1;
      last_on_reg <= 1'b0;
      since_reg   <= '0;
      on_time_reg <= '0;
      short_reg   <= '0;
      exc_reg     <= '0;
    end else if (mode == MODE_OFF || unl_reg > total) begin
      unl_reg     <= 5'd1;
      last_on_reg <= 1'b0;
      since_reg   <= '0;
      short_reg   <= '0;
      exc_reg     <= '0;
    end else if (unl_reg < total &&
                 short_reg >= {16'h0000, cat_p[ncat][K_ENI]}) begin
      unl_reg     <= unl_reg + 5'd1;
      last_on_reg <= 1'b1;
      since_reg   <= '0;
      on_time_reg <= '0;
      short_reg   <= '0;
      exc_reg     <= '0;
    end else if (unl_reg > 5'd1 &&
                 exc_reg >= {16'h0000, cat_p[lcat][K_INHI]} &&
                 on_time_reg >= cat_p[lcat][K_MINON]) begin
      unl_reg     <= unl_reg - 5'd1;
      last_on_reg <= 1'b0;
      since_reg   <= '0;
      short_reg   <= '0;
      exc_reg     <= '0;
    end else if (!last_on_reg && dev > half) begin
      last_on_reg <= 1'b1;
      since_reg   <= '0;
      on_time_reg <= '0;
    end else if (last_on_reg && dev < -half &&
                 on_time_reg >= cat_p[lcat][K_MINON]) begin
      last_on_reg <= 1'b0;
      since_reg   <= '0;
    end else if (tick) begin
      if (since_reg != 16'hFFFF) begin
        since_reg <= since_reg + 16'd1;
      end
      if (on_time_reg != 16'hFFFF) begin
        on_time_reg <= on_time_reg + 16'd1;
      end
      // Integrals wait for the stage to settle
      if (since_reg >= cat_p[lcat][K_INHT]) begin
        if (dev > 0) begin
          short_reg <= short_reg + 32'(dev);
        end else if (dev < 0) begin
          exc_reg   <= exc_reg + 32'(-dev);
        end
      end
    end
  end

  // Alarm contact and event log
  logic alarm_now;
  assign alarm_now = (|unit_alarm_in) || water_alarm_in;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alarm_reg    <= 1'b0;
      alarm_no_out <= 1'b0;
      alarm_nc_out <= 1'b1;
      acnt_reg     <= '0;
      for (int i = 0; i < NLOG; i++) begin
        alog_reg[i] <= '0;
      end
    end else begin
      alarm_reg    <= alarm_now;
      alarm_no_out <= alarm_now;
      alarm_nc_out <= !alarm_now;
      // Log holds only the low unit bits, to fit one word
      if (alarm_now && !alarm_reg) begin
        acnt_reg    <= acnt_reg + 16'd1;
        alog_reg[0] <= {water_alarm_in, unit_alarm_in[14:0]};
        for (int i = 1; i < NLOG; i++) begin
          alog_reg[i] <= alog_reg[i - 1];
        end
      end
    end
  end

  // Serial receiver
  csr_mb_t     st_reg;
  logic        rx_busy_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_sh_reg;
  logic        rx_vld;
  logic [19:0] gap_reg;
  logic        fe;
  logic [7:0]  rx_buf [REQ_LEN];
  logic [3:0]  rx_len_reg;
  logic [15:0] rx_crc_reg;

  assign rx_vld = rx_busy_reg && rx_cnt_reg == '0 &&
                  rx_bit_reg == 4'd9 && modbus_rx_in;
  assign fe     = gap_reg == 20'(GAP_BITS * BIT_CYC) &&
                  rx_len_reg != '0;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg  <= '0;
      rx_bit_reg  <= '0;
      rx_sh_reg   <= '0;
    end else if (!rx_busy_reg) begin
      // Own replies are not heard: line is half duplex
      if (!modbus_rx_in && st_reg == MB_RX) begin
        rx_busy_reg <= 1'b1;
        rx_cnt_reg  <= 16'(BIT_CYC / 2);
        rx_bit_reg  <= '0;
      end
    end else if (rx_cnt_reg == '0) begin
      rx_cnt_reg <= 16'(BIT_CYC - 1);
      rx_bit_reg <= rx_bit_reg + 4'd1;
      if ((rx_bit_reg == '0 && modbus_rx_in) ||
          rx_bit_reg == 4'd9) begin
        rx_busy_reg <= 1'b0;
      end
      if (rx_bit_reg != '0 && rx_bit_reg != 4'd9) begin
        rx_sh_reg <= {modbus_rx_in, rx_sh_reg[7:1]};
      end
    end else begin
      rx_cnt_reg <= rx_cnt_reg - 16'd1;
    end
  end

  // Frame ends after 3.5 silent characters
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_reg    <= '0;
      rx_len_reg <= '0;
      rx_crc_reg <= CRC_INIT;
      for (int i = 0; i < REQ_LEN; i++) begin
        rx_buf[i] <= '0;
      end
    end else begin
      if (rx_busy_reg || !modbus_rx_in) begin
        gap_reg <= '0;
      end else if (gap_reg != 20'(GAP_BITS * BIT_CYC)) begin
        gap_reg <= gap_reg + 20'd1;
      end
      if (fe) begin
        rx_len_reg <= '0;
        rx_crc_reg <= CRC_INIT;
      end else if (rx_vld) begin
        if (rx_len_reg < 4'(REQ_LEN)) begin
          rx_buf[rx_len_reg[2:0]] <= rx_sh_reg;
        end
        if (rx_len_reg != 4'hF) begin
          rx_len_reg <= rx_len_reg + 4'd1;
        end
        rx_crc_reg <= crc_byte(rx_crc_reg, rx_sh_reg);
      end
    end
  end

  // Request decode
  function automatic logic is_stg(input logic [15:0] a);
    return a >= 16'(C_CAT) && a < 16'(C_CAT + NCAT * C_STRIDE) &&
           (a - 16'(C_CAT)) % 16'(C_STRIDE) == 16'(K_STG);
  endfunction

  // Reset value of each writable word; bands start disabled
  function automatic logic [15:0] cfg_rst(input int i);
    logic [15:0] v;
    int          k;
    v = '0;
    k = (i - C_CAT) % C_STRIDE;
    if (i == C_SETPT) begin
      v = SETPT_RST;
    end else if (i == C_BAND) begin
      v = BAND_RST;
    end else if (i == C_RUN) begin
      v = RUN_RST;
    end else if (i >= C_CAT && i < C_CAT + NCAT * C_STRIDE) begin
      case (k)
        K_STG:   v = STG_RST;
        K_INHT:  v = INHT_RST;
        K_ENI:   v = ENI_RST;
        K_INHI:  v = INHI_RST;
        K_MINON: v = MINON_RST;
        default: v = '0;
      endcase
    end
    return v;
  endfunction

  logic [15:0] m_adr;
  logic [15:0] m_val;
  logic        ok_frame;
  logic [7:0]  r_ex;
  logic [4:0]  r_len;
  logic        wr_en;
  logic [16:0] m_end;

  assign m_adr    = {rx_buf[2], rx_buf[3]};
  assign m_val    = {rx_buf[4], rx_buf[5]};
  assign m_end    = {1'b0, m_adr} + {1'b0, m_val};
  assign ok_frame = rx_len_reg == 4'(REQ_LEN) &&
                    rx_crc_reg == '0 &&
                    rx_buf[0] == SLAVE_ADDR;

  always_comb begin
    r_ex  = '0;
    r_len = 5'(ECHO_LEN);
    wr_en = 1'b0;
    if (rx_buf[1] == FN_RD) begin
      if (m_val == '0 || m_val > 16'(MAX_QTY)) begin
        r_ex = EX_VAL;
      end else if (m_end <= 17'(NCFG) ||
                   (m_adr >= ST_BASE &&
                    m_end <= 17'(ST_BASE) + 17'(ST_N))) begin
        r_len = 5'(RD_HDR) + 5'(m_val << 1);
      end else begin
        r_ex = EX_ADR;
      end
    end else if (rx_buf[1] == FN_WR) begin
      if (m_adr >= 16'(NCFG)) begin
        r_ex = EX_ADR;
      end else if (is_stg(m_adr) && (m_val < 16'(STG_MIN) ||
                                     m_val > 16'(STG_MAX))) begin
        r_ex = EX_VAL;
      end else begin
        wr_en = fe && ok_frame;
      end
    end else begin
      r_ex = EX_FN;
    end
    if (r_ex != '0) begin
      r_len = 5'(EXC_LEN);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg_reg[i] <= cfg_rst(i);
      end
    end else if (wr_en) begin
      cfg_reg[m_adr[5:0]] <= m_val;
    end
  end

  // Reply generation
  logic [4:0]  tx_len_reg;
  logic [4:0]  tx_idx_reg;
  logic [7:0]  tx_ex_reg;
  logic [7:0]  tx_fn_reg;
  logic [15:0] tx_adr_reg;
  logic [15:0] tx_crc_reg;
  logic [9:0]  tx_sh_reg;
  logic [3:0]  tx_bits_reg;
  logic [15:0] tx_cnt_reg;
  logic [15:0] rd_adr;
  logic [15:0] rd_word;
  logic [7:0]  gen;

  assign rd_adr = tx_adr_reg + 16'((tx_idx_reg - 5'(RD_HDR)) >> 1);

  always_comb begin
    rd_word = '0;
    if (rd_adr < ST_BASE) begin
      rd_word = cfg_reg[rd_adr[5:0]];
    end else begin
      case (rd_adr - ST_BASE)
        16'(ST_SUP):  rd_word = temps_in.supply;
        16'(ST_RET):  rd_word = temps_in.ret;
        16'(ST_REG):  rd_word = reg_t;
        16'(ST_UNL):  rd_word = {11'h000, unl_reg};
        16'(ST_STG0): rd_word = {6'h00, stage_on_out[NSTG-1:0]};
        16'(ST_STG1): rd_word = {6'h00, stage_on_out[2*NSTG-1:NSTG]};
        16'(ST_ALM):  rd_word = {water_alarm_in, unit_alarm_in[14:0]};
        16'(ST_ACNT): rd_word = acnt_reg;
        default: begin
          if (rd_adr - ST_BASE < 16'(ST_N)) begin
            rd_word = alog_reg[2'(rd_adr - ST_BASE - 16'(ST_LOG))];
          end
        end
      endcase
    end
  end

  always_comb begin
    if (tx_idx_reg == 5'd0) begin
      gen = SLAVE_ADDR;
    end else if (tx_idx_reg == 5'd1) begin
      gen = (tx_ex_reg != '0) ? (tx_fn_reg | FN_EXC) : tx_fn_reg;
    end else if (tx_ex_reg != '0) begin
      gen = tx_ex_reg;
    end else if (tx_fn_reg == FN_WR) begin
      gen = rx_buf[tx_idx_reg[2:0]];
    end else if (tx_idx_reg == 5'd2) begin
      gen = 8'(tx_len_reg - 5'(RD_HDR));
    end else begin
      gen = tx_idx_reg[0] ? rd_word[15:8] : rd_word[7:0];
    end
  end

  // Answers only a frame addressed to it and intact
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg      <= MB_RX;
      tx_len_reg  <= '0;
      tx_idx_reg  <= '0;
      tx_ex_reg   <= '0;
      tx_fn_reg   <= '0;
      tx_adr_reg  <= '0;
      tx_crc_reg  <= CRC_INIT;
      tx_sh_reg   <= '1;
      tx_bits_reg <= '0;
      tx_cnt_reg  <= '0;
    end else begin
      case (st_reg)
        MB_RX: begin
          if (fe && ok_frame) begin
            st_reg      <= MB_TX;
            tx_len_reg  <= r_len;
            tx_ex_reg   <= r_ex;
            tx_fn_reg   <= rx_buf[1];
            tx_adr_reg  <= m_adr;
            tx_idx_reg  <= '0;
            tx_crc_reg  <= CRC_INIT;
            tx_bits_reg <= '0;
          end
        end
        MB_TX: begin
          if (tx_bits_reg == '0) begin
            tx_bits_reg <= 4'd10;
            tx_cnt_reg  <= 16'(BIT_CYC - 1);
            tx_idx_reg  <= tx_idx_reg + 5'd1;
            if (tx_idx_reg < tx_len_reg) begin
              tx_sh_reg  <= {1'b1, gen, 1'b0};
              tx_crc_reg <= crc_byte(tx_crc_reg, gen);
            end else if (tx_idx_reg == tx_len_reg) begin
              tx_sh_reg  <= {1'b1, tx_crc_reg[7:0], 1'b0};
            end else if (tx_idx_reg == tx_len_reg + 5'd1) begin
              tx_sh_reg  <= {1'b1, tx_crc_reg[15:8], 1'b0};
            end else begin
              st_reg      <= MB_RX;
              tx_bits_reg <= '0;
            end
          end else if (tx_cnt_reg == '0) begin
            tx_cnt_reg  <= 16'(BIT_CYC - 1);
            tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
            tx_bits_reg <= tx_bits_reg - 4'd1;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'd1;
          end
        end
        default: st_reg <= MB_RX;
      endcase
    end
  end

  assign modbus_tx_out = tx_sh_reg[0];
  assign modbus_de_out = st_reg == MB_TX;
endmodule // csr_regulator

// File: csr_monitor.sv
/*
  Port checker for the cascade stage regulator.
  Assumes the mode and run words keep their reset values.
*/
module csr_monitor import csr_pkg::*; #(
  parameter int BIT_CYC = 16
) (
  input wire logic                 clk_sys_in,
  input wire logic                 rst_n_in,
  input wire logic [1:0]           selector_in,
  input wire logic [NCAT*NSTG-1:0] unit_alarm_in,
  input wire logic                 water_alarm_in,
  input wire logic                 modbus_rx_in,
  input wire logic                 modbus_tx_out,
  input wire logic                 modbus_de_out,
  input wire logic [NCAT*NSTG-1:0] stage_on_out,
  input wire logic                 heat_out,
  input wire logic                 cool_out,
  input wire logic                 alarm_no_out,
  input wire logic                 alarm_nc_out
);
  logic alm;
  int   idle_cnt;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  assign alm = (|unit_alarm_in) | water_alarm_in;
  // Counts from the last low level, so it overshoots the true gap
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_cnt <= 0;
    end else begin
      idle_cnt <= modbus_rx_in ? idle_cnt + 1 : 0;
    end
  end
  heat_mode_a: assert property (
    (rst_n_in && selector_in[0]) [*2] |-> heat_out && !cool_out)
    else $error("heat mode wrong");
  cool_mode_a: assert property (
    (rst_n_in && selector_in == 2'h2) [*2] |-> cool_out && !heat_out)
    else $error("cool mode wrong");
  sys_off_a: assert property (
    (!heat_out && !cool_out) [*2] |-> stage_on_out == 20'h00000)
    else $error("stage on while off");
  alarm_no_a: assert property (
    rst_n_in |=> alarm_no_out == $past(alm))
    else $error("alarm contact wrong");
  nc_pair_a: assert property (
    alarm_nc_out == !alarm_no_out)
    else $error("contact sides disagree");
  stage_cnt_a: assert property (
    stage_on_out[9:1] == 9'h000 && stage_on_out[19:11] == 9'h000)
    else $error("unconfigured stage on");
  first_stg_a: assert property (
    stage_on_out[10] |-> stage_on_out[0])
    else $error("earlier stage not held on");
  tx_idle_a: assert property (
    !modbus_de_out |-> modbus_tx_out)
    else $error("line driven while idle");
  reply_start_a: assert property (
    $rose(modbus_de_out) |-> modbus_tx_out ##1 !modbus_tx_out)
    else $error("start bit late");
  gap_wait_a: assert property (
    $rose(modbus_de_out) |-> idle_cnt >= GAP_BITS * BIT_CYC &&
      idle_cnt <= (GAP_BITS + 11) * BIT_CYC)
    else $error("reply without frame gap");
endmodule // csr_monitor

bind csr_regulator csr_monitor #(.BIT_CYC(BIT_CYC)) mon (
  .clk_sys_in, .rst_n_in, .selector_in, .unit_alarm_in, .water_alarm_in,
  .modbus_rx_in, .modbus_tx_out, .modbus_de_out, .stage_on_out,
  .heat_out, .cool_out, .alarm_no_out, .alarm_nc_out);

// File: csr_master.sv
/*
  Serial master model standing in for the building supervisor.
  Assumes an idle-high line, 8N1 framing and BIT cycles per bit.
*/
module csr_master #(
  parameter int BIT = 16
) (
  input  wire logic clk_in,
  input  wire logic rx_in,
  output logic      tx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rsp[$];
  initial tx_out = 1'b1; // Bias holds the idle line high
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in) tx_out <= f[i];
      repeat (BIT - 1) @(posedge clk_in);
    end
  endtask
  task automatic xfer(input logic [47:0] q);
    logic [15:0] c;
    logic [7:0]  b;
    int          w;
    c = 16'hFFFF;
    rsp = {};
    repeat (40 * BIT) @(posedge clk_in); // Master opens every frame
    for (int k = 5; k >= 0; k--) begin
      b = q[k*8+:8];
      c = c ^ {8'h00, b};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      put(b);
    end
    put(c[7:0]);
    put(c[15:8]);
    w = 0;
    // Silence of 60 bit times ends the reply
    while (w < 60 * BIT) begin
      @(posedge clk_in);
      w++;
      if (!rx_in) begin
        repeat (BIT / 2) @(posedge clk_in);
        for (int j = 0; j < 8; j++) begin
          repeat (BIT) @(posedge clk_in);
          b[j] = rx_in;
        end
        rsp.push_back(b);
        repeat (BIT) @(posedge clk_in);
        w = 0;
      end
    end
  endtask
endmodule // csr_master

// File: test_csr_regulator.sv
/*
  Testbench of the cascade stage regulator with a serial master.
  Assumes short bit and tick counts to keep the run brief.
*/
module test_csr_regulator import csr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MD = 8'h98;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  csr_temps_t  temps = 32'h01CC01C8;
  logic [1:0]  sel = 2'h1;
  logic [19:0] ualm = 20'h00000;
  logic        walm = 1'b0;
  logic        rx, tx, de, heat, cool, no, nc;
  logic [19:0] stg;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  csr_regulator #(.BIT_CYC(16), .TICK_CYC(20)) uut (
    .clk_sys_in, .rst_n_in, .temps_in(temps), .selector_in(sel),
    .time_of_day_in(11'h000), .unit_alarm_in(ualm),
    .water_alarm_in(walm), .modbus_rx_in(rx), .modbus_tx_out(tx),
    .modbus_de_out(de), .stage_on_out(stg), .heat_out(heat),
    .cool_out(cool), .alarm_no_out(no), .alarm_nc_out(nc));
  csr_master #(.BIT(16)) m (.clk_in(clk_sys_in), .rx_in(tx), .tx_out(rx));
  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic mb(input logic [47:0] q, input int n, input logic [15:0] w);
    m.xfer(q);
    chk(m.rsp.size(), n);
    if (n > 0) begin
      chk({m.rsp[0], m.rsp[n-4], m.rsp[n-3]}, {8'h01, w});
    end
  endtask
  // Bounded wait, since tick timing inside is the design's own
  task automatic wt(input int b, input logic v, input int lim);
    repeat (lim) begin
      @(posedge clk_sys_in);
      if (stg[b] === v) break;
    end
    #1 chk(stg[b], v);
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    cy(4);
    #1 chk({tx, de, stg, heat, cool, no, nc}, 26'h2000001);
    @(posedge clk_sys_in) rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in) sel <= 2'(i);
      cy(3);
      #1 chk({heat, cool}, MD[2*i+:2]);
    end
    @(posedge clk_sys_in) {sel, walm} <= 3'h3;
    cy(2);
    #1 chk({no, nc}, 2'h2);
    @(posedge clk_sys_in) {walm, ualm} <= 21'h000001;
    cy(2);
    #1 chk({no, nc}, 2'h2);
    @(posedge clk_sys_in) ualm <= 20'h00000;
    cy(2);
    #1 chk({no, nc}, 2'h1);
    mb(48'h010300010001, 7, 16'h0014);
    mb(48'h010301010001, 7, 16'h01C8);
    mb(48'h0106000001CC, 8, 16'h01CC);
    mb(48'h010300000001, 7, 16'h01CC);
    mb(48'h01060005000B, 5, 16'h8603);
    mb(48'h010600050000, 5, 16'h8603);
    mb(48'h010400000001, 5, 16'h8401);
    mb(48'h010300240001, 5, 16'h8302);
    mb(48'h010300000009, 5, 16'h8303);
    mb(48'h020300000001, 0, 16'h0000);
    mb(48'h010301070001, 7, 16'h0001);
    mb(48'h010301080001, 7, 16'h8000);
    // Zero min on-time lets band switching act before a lock
    mb(48'h010600120000, 8, 16'h0000);
    @(posedge clk_sys_in) temps <= 32'h019001C8;
    wt(0, 1'b1, 200);
    cy(1000);
    #1 chk(stg[10], 1'b0);
    wt(10, 1'b1, 3000);
    @(posedge clk_sys_in) temps <= 32'h023001C8;
    wt(10, 1'b0, 3000);
    chk(stg[0], 1'b1);
    wt(0, 1'b0, 8000);
    @(posedge clk_sys_in) temps <= 32'h019001C8;
    wt(0, 1'b1, 200);
    @(posedge clk_sys_in) sel <= 2'h0;
    cy(3);
    #1 chk(stg, 20'h00000);
    test_done();
  end
endmodule // test_csr_regulator
